//--- hw/gpc_pkg.sv
// Purpose: Shared constants and types for the two-port general I/O block
// Assumes: 8-bit register port, one clock, two ports of eight pins
// Notes:   Offsets are byte indices on the plain register port
package gpc_pkg;

  // Port geometry
  localparam int unsigned PINS  = 8;
  localparam int unsigned PORTS = 2;

  // Register offsets
  localparam logic [7:0] ADDR_P0_IN   = 8'h00;
  localparam logic [7:0] ADDR_P0_DIR  = 8'h01;
  localparam logic [7:0] ADDR_P0_OUT  = 8'h02;
  localparam logic [7:0] ADDR_P1_IN   = 8'h03;
  localparam logic [7:0] ADDR_P1_DIR  = 8'h04;
  localparam logic [7:0] ADDR_P1_OUT  = 8'h05;
  localparam logic [7:0] ADDR_MCU_CTL = 8'h06;
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h07;
  localparam logic [7:0] ADDR_MASK0   = 8'h6b;
  localparam logic [7:0] ADDR_MASK1   = 8'h6c;

  // Field positions
  localparam int unsigned POS_PULLUP_OFF = 4;
  localparam int unsigned POS_GRP0_EN    = 4;
  localparam int unsigned POS_GRP1_EN    = 5;

  // Values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic       RST_BIT  = 1'b0;

  // Sampling delay of a software-driven pin, in clock periods
  localparam int unsigned READBACK_CYCLES = 1;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } gpc_bus_type;

  // Pad controls of one port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull;
  } gpc_pad_type;

  // Alternate-function direction override of one port
  typedef struct packed {
    logic [7:0] own;
    logic [7:0] dir;
  } gpc_alt_type;

endpackage

//--- hw/gpc_port_pins.sv
// Purpose: Pad drivers and input synchroniser of one eight-pin port
// Assumes: Control inputs are next-state values of the register file
// Notes:   Pad controls clear without a clock so the pins float in reset
`timescale 1ns/1ps
module gpc_port_pins (
  // Clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_nrst,
  // Register-file controls
  input  wire logic [7:0]        i_dir_nxt,
  input  wire logic [7:0]        i_out_nxt,
  input  wire logic              i_pullup_off_nxt,
  input  wire gpc_pkg::gpc_alt_type i_alt,
  // Sleep clamp and its per-pin override
  input  wire logic              i_sleep,
  input  wire logic [7:0]        i_keep_awake,
  // Pad side
  input  wire logic [7:0]        i_pad_in,
  output gpc_pkg::gpc_pad_type   o_pad,
  output logic [7:0]             o_sample
);
  import gpc_pkg::*;

  logic [7:0] dir_eff;
  logic [7:0] pin_in;
  logic [7:0] sync_latch;

  // Alternate owner only overrides its own pins, the rest stay general I/O
  // per-pin override
  assign dir_eff = (i_alt.own & i_alt.dir) | (~i_alt.own & i_dir_nxt);

  assign pin_in = i_pad_in & ~(i_sleep ? ~i_keep_awake : 8'h00);

  // Drive flops clear without a clock so the pads float even with no clock
  // asynchronous tri-state
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pad <= '0;
    end else begin
      o_pad.oe   <= dir_eff;
      o_pad.out  <= i_out_nxt;
      o_pad.pull <= ~dir_eff & i_out_nxt & {8{~i_pullup_off_nxt}};
    end
  end

  // Latch is open while the clock is high and holds while it is low
  // latch stage
  always_latch begin
    if (i_ref_clk) begin
      // Non-blocking so the register stage takes the value held at the falling edge
      sync_latch <= pin_in;
    end
  end

  // Second stage; the latch feeds nothing else
  // register stage
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_sample <= RST_BYTE;
    end else begin
      o_sample <= sync_latch;
    end
  end

endmodule

//--- hw/gpc_top.sv
// Purpose: Two-port general I/O block with pin-change enable masks
// Assumes: Byte-wide register port, reads answered in the following cycle
// Notes:   Pins are three signals each; the bench resolves the wire level
`timescale 1ns/1ps
module gpc_top (
  // Clock and reset
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_nrst,
  // Register port
  input  wire gpc_pkg::gpc_bus_type        i_bus,
  output logic [7:0]                       o_rd_data,
  // Pads, one group per port
  input  wire logic [1:0][7:0]             i_pad_in,
  output gpc_pkg::gpc_pad_type [1:0]       o_pad,
  // Alternate-function overrides and sleep
  input  wire gpc_pkg::gpc_alt_type [1:0]  i_alt,
  input  wire logic                        i_sleep,
  // Pins armed for change detection
  output logic [1:0][7:0]                  o_change_armed
);
  import gpc_pkg::*;

  // Whole register state of the block
  typedef struct packed {
    logic [1:0][7:0] dir;
    logic [1:0][7:0] out;
    logic            pullup_off;
    logic            grp0_en;
    logic            grp1_en;
    logic [7:0]      mask0;
    logic [7:0]      mask1;
    logic [7:0]      rd_data;
    logic [1:0][7:0] armed;
  } gpc_state_type;

  gpc_state_type   st_r;
  gpc_state_type   st_nxt;
  logic [1:0][7:0] sample;
  logic [1:0][7:0] armed_now;
  logic [7:0]      rd_mux;

  // Pins armed right now; also used to keep them awake in sleep
  // per-group enable gating
  assign armed_now[0] = st_r.mask0 & {8{st_r.grp0_en}};
  assign armed_now[1] = st_r.mask1 & {8{st_r.grp1_en}};

  // Read selection; unmapped addresses read zero
  always_comb begin
    rd_mux = 8'h00;
    case (i_bus.addr)
      ADDR_P0_IN:   rd_mux = sample[0];
      ADDR_P0_DIR:  rd_mux = st_r.dir[0];
      ADDR_P0_OUT:  rd_mux = st_r.out[0];
      ADDR_P1_IN:   rd_mux = sample[1];
      ADDR_P1_DIR:  rd_mux = st_r.dir[1];
      ADDR_P1_OUT:  rd_mux = st_r.out[1];
      ADDR_MCU_CTL: rd_mux[POS_PULLUP_OFF] = st_r.pullup_off;
      ADDR_IRQ_MSK: begin
        rd_mux[POS_GRP0_EN] = st_r.grp0_en;
        rd_mux[POS_GRP1_EN] = st_r.grp1_en;
      end
      ADDR_MASK0:   rd_mux = st_r.mask0;
      ADDR_MASK1:   rd_mux = st_r.mask1;
      default:      rd_mux = 8'h00;
    endcase
  end

  // Next state: register writes, read data and armed flags
  always_comb begin
    st_nxt         = st_r;
    st_nxt.armed   = armed_now;
    // Read data stand for one cycle only, zero otherwise
    st_nxt.rd_data = i_bus.rd ? rd_mux : 8'h00;
    if (i_bus.wr) begin
      case (i_bus.addr)
        ADDR_P0_IN:   st_nxt.out[0] = st_r.out[0] ^ i_bus.wdata;
        // whole-byte write, bits not changed by software keep value
        ADDR_P0_DIR:  st_nxt.dir[0] = i_bus.wdata;
        ADDR_P0_OUT:  st_nxt.out[0] = i_bus.wdata;
        ADDR_P1_IN:   st_nxt.out[1] = st_r.out[1] ^ i_bus.wdata;
        ADDR_P1_DIR:  st_nxt.dir[1] = i_bus.wdata;
        ADDR_P1_OUT:  st_nxt.out[1] = i_bus.wdata;
        ADDR_MCU_CTL: st_nxt.pullup_off = i_bus.wdata[POS_PULLUP_OFF];
        ADDR_IRQ_MSK: begin
          st_nxt.grp0_en = i_bus.wdata[POS_GRP0_EN];
          st_nxt.grp1_en = i_bus.wdata[POS_GRP1_EN];
        end
        ADDR_MASK0:   st_nxt.mask0 = i_bus.wdata;
        ADDR_MASK1:   st_nxt.mask1 = i_bus.wdata;
        default:      st_nxt.mask0 = st_r.mask0;
      endcase
    end
  end

  // State register with synchronous reset
  // cleared direction and data
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Pads see next-state controls so a written value is sampled one period
  // later, matching the single nop software inserts before reading back.
  // one-period readback
  genvar p;
  generate
    for (p = 0; p < PORTS; p = p + 1) begin : g_port
      gpc_port_pins u_pins (
        .i_ref_clk        (i_ref_clk),
        .i_nrst           (i_nrst),
        .i_dir_nxt        (i_nrst ? st_nxt.dir[p] : RST_BYTE),
        .i_out_nxt        (i_nrst ? st_nxt.out[p] : RST_BYTE),
        .i_pullup_off_nxt (st_nxt.pullup_off),
        .i_alt            (i_alt[p]),
        .i_sleep          (i_sleep),
        .i_keep_awake     (armed_now[p]),
        .i_pad_in         (i_pad_in[p]),
        .o_pad            (o_pad[p]),
        .o_sample         (sample[p])
      );
    end
  endgenerate

  // Outputs straight from flops
  assign o_rd_data      = st_r.rd_data;
  assign o_change_armed = st_r.armed;

endmodule

//--- sim/gpc_sva.sv
// Purpose: Port checks for the I/O block
// Assumes: Alternate overrides idle on port 0
// Notes:   Reset disables every check
`timescale 1ns/1ps
module gpc_sva (
  // Clock and reset
  input wire logic                       i_ref_clk,
  input wire logic                       i_nrst,
  // Watched ports
  input wire gpc_pkg::gpc_bus_type       i_bus,
  input wire gpc_pkg::gpc_alt_type [1:0] i_alt,
  input wire logic [7:0]                 o_rd_data,
  input wire gpc_pkg::gpc_pad_type [1:0] o_pad,
  input wire logic [1:0][7:0]            o_change_armed
);
  import gpc_pkg::*;
  // One domain, so clock and reset are given once
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  chk_reset_idle: assert property ($rose(i_nrst) |-> o_pad == '0)
    else $error("pads not idle after reset");
  chk_dir_write: assert property (i_bus.wr && i_bus.addr == ADDR_P0_DIR
    && i_alt[0].own == 8'h00 |=> o_pad[0].oe == $past(i_bus.wdata))
    else $error("drive enable differs from direction");
  chk_out_write: assert property (i_bus.wr && i_bus.addr == ADDR_P1_OUT
    |=> o_pad[1].out == $past(i_bus.wdata))
    else $error("drive value differs from data");
  chk_toggle_out: assert property (i_bus.wr && i_bus.addr == ADDR_P0_IN
    |=> o_pad[0].out == ($past(o_pad[0].out) ^ $past(i_bus.wdata)))
    else $error("toggle write wrong");
  chk_pull_gate: assert property (
    (o_pad[0].pull & (o_pad[0].oe | ~o_pad[0].out)) == 8'h00)
    else $error("pull-up on output or zero pin");
  chk_pull_off: assert property (i_bus.wr && i_bus.addr == ADDR_MCU_CTL
    && i_bus.wdata[POS_PULLUP_OFF] |=> o_pad[0].pull == 8'h00 && o_pad[1].pull == 8'h00)
    else $error("pull-up left on");
  chk_grp0_off: assert property (i_bus.wr && i_bus.addr == ADDR_IRQ_MSK
    && !i_bus.wdata[POS_GRP0_EN] |=> ##1 o_change_armed[0] == 8'h00)
    else $error("group zero armed while disabled");
  chk_mask0_off: assert property (i_bus.wr && i_bus.addr == ADDR_MASK0
    && i_bus.wdata == 8'h00 |=> ##1 o_change_armed[0] == 8'h00)
    else $error("masked pin still armed");
endmodule
bind gpc_top gpc_sva u_sva (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_bus(i_bus),
  .i_alt(i_alt), .o_rd_data(o_rd_data), .o_pad(o_pad), .o_change_armed(o_change_armed));

//--- sim/gpc_ext_pads.sv
// Purpose: Board circuitry on the pads of both ports
// Assumes: No board pull-down; the bench never fights a driven pin
// Notes:   Floating pins wander so a stale level never passes
`timescale 1ns/1ps
module gpc_ext_pads (
  // Clock
  input  wire logic                       i_ref_clk,
  // Block pads and board drive
  input  wire gpc_pkg::gpc_pad_type [1:0] i_pad,
  input  wire logic [1:0][7:0]            i_drv_en,
  input  wire logic [1:0][7:0]            i_drv_val,
  output logic [1:0][7:0]                 o_lvl
);
  // Wander pattern for undriven, unpulled pins
  logic flip_r = 1'b0;
  always_ff @(posedge i_ref_clk) flip_r <= ~flip_r;
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      o_lvl[p] = (i_pad[p].oe & i_pad[p].out) | (~i_pad[p].oe & i_drv_en[p] & i_drv_val[p])
        | (~i_pad[p].oe & ~i_drv_en[p] & (i_pad[p].pull | {8{flip_r}}));
    end
  end
endmodule

//--- sim/gpc_top_tb.sv
// Purpose: Self-checking bench for the I/O block
// Assumes: Alternate functions idle outside t_alt, sleep idle outside t_sleep
// Notes:   Pad levels come from the board model
`timescale 1ns/1ps
module gpc_top_tb;
  import gpc_pkg::*;
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  gpc_bus_type       bus = '0;
  gpc_alt_type [1:0] alt = '0;
  logic [1:0][7:0]   drv_en = '0;
  logic [1:0][7:0]   drv_val = '0;
  logic              sleep = 1'b0;
  logic [1:0][7:0]   lvl;
  logic [1:0][7:0]   armed;
  logic [7:0]        rdata;
  gpc_pad_type [1:0] pad;
  int                n_fail = 0;
  int                compares = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  gpc_top u_dut (.i_ref_clk(clk), .i_nrst(nrst), .i_bus(bus), .o_rd_data(rdata),
    .i_pad_in(lvl), .o_pad(pad), .i_alt(alt), .i_sleep(sleep), .o_change_armed(armed));
  gpc_ext_pads u_ext (.i_ref_clk(clk), .i_pad(pad), .i_drv_en(drv_en),
    .i_drv_val(drv_val), .o_lvl(lvl));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Bus cycles; the trailing delay lets the taken edge settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic t_reset();
    logic [7:0] ra [9];
    ra = '{ADDR_P0_DIR, ADDR_P0_OUT, ADDR_P1_DIR, ADDR_P1_OUT, ADDR_MCU_CTL,
      ADDR_IRQ_MSK, ADDR_MASK0, ADDR_MASK1, 8'h40};
    foreach (ra[i]) rd(ra[i], 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_drive();
    wr(ADDR_P0_OUT, 8'ha5);
    wr(ADDR_P0_DIR, 8'hff);
    chk(pad[0].oe, 8'hff);
    rd(ADDR_P0_IN, 8'ha5);
    wr(ADDR_P0_IN, 8'h0f);
    rd(ADDR_P0_OUT, 8'haa);
    wr(ADDR_P0_DIR, 8'hfe);
    chk(pad[0].oe, 8'hfe);
    rd(ADDR_P0_OUT, 8'haa);
    // Read data stand one cycle only, then drop to zero
    @(posedge clk) #1 chk(rdata, 8'h00);
    wr(ADDR_P0_OUT, 8'hab);
    chk(pad[0].pull, 8'h01);
    // Pulled-up to driven low through high impedance
    wr(ADDR_P0_OUT, 8'haa);
    wr(ADDR_P0_DIR, 8'hff);
    chk(pad[0].pull, 8'h00);
    chk(pad[0].oe, 8'hff);
    $display("t_drive done");
  endtask
  task automatic t_ext();
    @(posedge clk) drv_en[1] <= 8'hff;
    drv_val[1] <= 8'h3c;
    rd(ADDR_P1_IN, 8'h3c);
    drv_en[1] <= 8'h00;
    wr(ADDR_P1_OUT, 8'hff);
    chk(pad[1].pull, 8'hff);
    rd(ADDR_P1_IN, 8'hff);
    wr(ADDR_MCU_CTL, 8'(8'h01 << POS_PULLUP_OFF));
    chk(pad[1].pull, 8'h00);
    $display("t_ext done");
  endtask
  task automatic t_mask();
    wr(ADDR_MASK0, 8'h81);
    wr(ADDR_MASK1, 8'h42);
    wr(ADDR_IRQ_MSK, 8'(8'h01 << POS_GRP1_EN));
    @(posedge clk) #1 chk(armed[1], 8'h42);
    chk(armed[0], 8'h00);
    wr(ADDR_IRQ_MSK, 8'(8'h01 << POS_GRP0_EN));
    @(posedge clk) #1 chk(armed[0], 8'h81);
    chk(armed[1], 8'h00);
    wr(ADDR_MASK0, 8'h00);
    @(posedge clk) #1 chk(armed[0], 8'h00);
    $display("t_mask done");
  endtask
  // Sleep clamps port 1 low except the pins armed by group one
  task automatic t_sleep();
    wr(ADDR_IRQ_MSK, 8'(8'h01 << POS_GRP1_EN));
    @(posedge clk) drv_en[1] <= 8'hff;
    drv_val[1] <= 8'hff;
    sleep <= 1'b1;
    rd(ADDR_P1_IN, 8'h42);
    @(posedge clk) sleep <= 1'b0;
    rd(ADDR_P1_IN, 8'hff);
    @(posedge clk) drv_en[1] <= 8'h00;
    $display("t_sleep done");
  endtask
  // Override on pin 0 of port 1 leaves pin 7 under its direction bit
  task automatic t_alt();
    @(posedge clk) alt[1] <= '{8'h01, 8'h01};
    wr(ADDR_P1_DIR, 8'h80);
    chk(pad[1].oe, 8'h81);
    rd(ADDR_P1_DIR, 8'h80);
    @(posedge clk) alt[1] <= '0;
    wr(ADDR_P1_DIR, 8'h00);
    chk(pad[1].oe, 8'h00);
    $display("t_alt done");
  endtask
  // Reset in mid-run: pads float at the reset edge, registers clear
  task automatic t_rst2();
    wr(ADDR_MCU_CTL, 8'h00);
    chk(pad[1].pull, 8'hff);
    @(posedge clk) nrst <= 1'b0;
    #1 chk(pad[0].oe, 8'h00);
    chk(pad[1].pull, 8'h00);
    repeat (9) @(posedge clk);
    #1 chk(pad[0].oe | pad[1].pull, 8'h00);
    chk(armed[1], 8'h00);
    @(posedge clk) nrst <= 1'b1;
    t_reset();
    $display("t_rst2 done");
  endtask
  task automatic end_sim();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Cut a hang short
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_drive();
    t_ext();
    t_mask();
    t_sleep();
    t_alt();
    t_rst2();
    end_sim();
  end
endmodule
